// [logic/mbm_pkg.sv]
package mbm_pkg;

   // =========================================================================
   // Register map (16-bit register addresses as seen by the master)
   // =========================================================================
   localparam logic [15:0] SCAN_BASE = 16'h1389;   // First scan-list slot.
   localparam logic [15:0] SCAN_LAST = 16'h1398;   // Last scan-list slot.
   localparam logic [15:0] DATA_BASE = 16'h13BB;   // Start register of slot 0.
   localparam logic [15:0] DATA_SLOT2 = 16'h13BD;  // Start register of slot 1.
   localparam logic [15:0] DATA_LSLOT = 16'h13D9;  // Start register of slot 15.
   localparam logic [15:0] DATA_LAST = 16'h13DA;   // End register of slot 15.
   localparam int          SLOTS     = 16;
   localparam logic [15:0] SCAN_RESET = 16'h0000;  // Empty entry.

   // =========================================================================
   // Byte-order setting encodings
   // =========================================================================
   localparam logic [1:0] ORD_1032 = 2'h0;
   localparam logic [1:0] ORD_0123 = 2'h1;
   localparam logic [1:0] ORD_2301 = 2'h2;
   localparam logic [1:0] ORD_3210 = 2'h3;
   localparam logic [1:0] ORD_RESET = ORD_1032;

   // =========================================================================
   // Scanner states
   // =========================================================================
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_REQ  = 3'b010,
      ST_WAIT = 3'b100
   } mbm_scan_state_t;

endpackage

// [logic/mbm_swap_if.sv]
`timescale 1ns/1ps

// Carries one value through the byte reorder network.
interface mbm_swap_if;
   logic [1:0]  order;
   logic        is_float;
   logic        to_wire;
   logic [31:0] din;
   logic [31:0] dout;

   modport user    (output order, output is_float, output to_wire, output din, input dout);
   modport swapper (input order, input is_float, input to_wire, input din, output dout);
endinterface

// [logic/mbm_byte_swap.sv]
`timescale 1ns/1ps

// Wire layout: dout[31:24] is the first byte sent, dout[7:0] the last.
// Integers and string register pairs use only the low 16 bits.
module mbm_byte_swap
(
   mbm_swap_if.swapper sw
);

   logic [7:0] b3;
   logic [7:0] b2;
   logic [7:0] b1;
   logic [7:0] b0;

   assign b3 = sw.din[31:24];
   assign b2 = sw.din[23:16];
   assign b1 = sw.din[15:8];
   assign b0 = sw.din[7:0];

   // =========================================================================
   // Reorder network
   // =========================================================================
   // Every order is its own inverse; the write path keeps its own table so that an
   // asymmetric order could be added without disturbing the read path.
   always_comb
   begin
      sw.dout = 32'h0000_0000;
      if (sw.is_float)
      begin
         unique case (sw.order)
            mbm_pkg::ORD_1032: sw.dout = sw.to_wire ? {b1, b0, b3, b2} : {b1, b0, b3, b2};
            mbm_pkg::ORD_0123: sw.dout = sw.to_wire ? {b0, b1, b2, b3} : {b0, b1, b2, b3};
            mbm_pkg::ORD_2301: sw.dout = sw.to_wire ? {b2, b3, b0, b1} : {b2, b3, b0, b1};
            mbm_pkg::ORD_3210: sw.dout = sw.din;
         endcase
         if (!sw.to_wire)
         begin
            unique case (sw.order)
               mbm_pkg::ORD_1032: sw.dout = {b1, b0, b3, b2};
               mbm_pkg::ORD_0123: sw.dout = {b0, b1, b2, b3};
               mbm_pkg::ORD_2301: sw.dout = {b2, b3, b0, b1};
               mbm_pkg::ORD_3210: sw.dout = sw.din;
            endcase
         end
      end
      else
      begin
         if (sw.order == mbm_pkg::ORD_1032 || sw.order == mbm_pkg::ORD_3210)
            sw.dout = {16'h0000, b1, b0};
         else
            sw.dout = {16'h0000, b0, b1};
      end
   end

endmodule

// [logic/mbm_data_map.sv]
`timescale 1ns/1ps

// Behaviour
// - Float bytes sent in selected order
// - Factory byte order is 1-0-3-2
// - Integer MSB first only for 1032/3210
// - Strings swap byte pairs under 0123/2301
// - Byte order configurable; master must match
// - Indirect map groups up to sixteen parameters
// - Whole data area accessible in one telegram
// - Cyclically fetch referenced parameter values
// - Scan list at registers 5001 to 5016
// - Slot n starts at 5051 plus 2n
// - Float uses two registers, integer one
// - Slot type follows referenced parameter
// - Slot writes forwarded only if writable
// - Float is IEEE single, two registers
module mbm_data_map
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic [15:0] reg_addr_in,
   input  wire logic        reg_rd_in,
   input  wire logic        reg_wr_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic      [15:0] reg_rdata_out,
   output logic             reg_ack_out,
   input  wire logic        byte_order_wr_in,
   input  wire logic [1:0]  byte_order_in,
   output logic      [1:0]  byte_order_out,
   output logic             par_rd_req_out,
   output logic      [15:0] par_rd_addr_out,
   input  wire logic        par_rd_ack_in,
   input  wire logic        par_rd_ok_in,
   input  wire logic        par_rd_float_in,
   input  wire logic        par_rd_writable_in,
   input  wire logic [31:0] par_rd_data_in,
   output logic             par_wr_out,
   output logic      [15:0] par_wr_addr_out,
   output logic      [31:0] par_wr_data_out,
   output logic             par_wr_float_out
);

   // =========================================================================
   // Storage
   // =========================================================================
   logic [15:0]             scan_reg [mbm_pkg::SLOTS];
   logic [31:0]             value_reg [mbm_pkg::SLOTS];
   logic [mbm_pkg::SLOTS-1:0] float_reg;
   logic [mbm_pkg::SLOTS-1:0] wable_reg;
   logic [mbm_pkg::SLOTS-1:0] valid_reg;
   logic [1:0]              order_reg;
   mbm_pkg::mbm_scan_state_t state_reg;
   logic [3:0]              idx_reg;
   logic [15:0]             stage_reg;
   logic [3:0]              stage_slot_reg;
   logic                    stage_valid_reg;

   // =========================================================================
   // Address decode
   // =========================================================================
   logic        hit_scan;
   logic        hit_data;
   logic [15:0] scan_off;
   logic [15:0] data_off;
   logic [3:0]  scan_idx;
   logic [3:0]  slot;
   logic        is_end;

   assign hit_scan = (reg_addr_in >= mbm_pkg::SCAN_BASE) && (reg_addr_in <= mbm_pkg::SCAN_LAST);
   assign scan_off = reg_addr_in - mbm_pkg::SCAN_BASE;
   assign scan_idx = scan_off[3:0];
   // slot start at base plus 2n
   assign hit_data = (reg_addr_in >= mbm_pkg::DATA_BASE) && (reg_addr_in <= mbm_pkg::DATA_LAST);
   assign data_off = reg_addr_in - mbm_pkg::DATA_BASE;
   assign slot     = data_off[4:1];
   assign is_end   = data_off[0];

   // =========================================================================
   // Byte reorder instances
   // =========================================================================
   mbm_swap_if rd_sw ();
   mbm_swap_if wr_sw ();

   assign rd_sw.order    = order_reg;
   assign rd_sw.is_float = float_reg[slot];
   assign rd_sw.to_wire  = 1'b1;
   assign rd_sw.din      = value_reg[slot];

   // The end register carries the second word of the pair just staged.
   assign wr_sw.order    = order_reg;
   assign wr_sw.is_float = float_reg[slot];
   assign wr_sw.to_wire  = 1'b0;
   assign wr_sw.din      = float_reg[slot] ? {stage_reg, reg_wdata_in} : {16'h0000, reg_wdata_in};

   mbm_byte_swap u_rd_swap
   (
      .sw (rd_sw.swapper)
   );

   mbm_byte_swap u_wr_swap
   (
      .sw (wr_sw.swapper)
   );

   // =========================================================================
   // Byte-order setting
   // =========================================================================
   // factory order after reset
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         order_reg <= mbm_pkg::ORD_RESET;
      else if (byte_order_wr_in)
         order_reg <= byte_order_in;
   end

   assign byte_order_out = order_reg;

   // =========================================================================
   // Scan list
   // =========================================================================
   // sixteen grouped slots
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < mbm_pkg::SLOTS; i++)
            scan_reg[i] <= mbm_pkg::SCAN_RESET;
      end
      else if (reg_wr_in && hit_scan)
         scan_reg[scan_idx] <= reg_wdata_in;
   end

   // =========================================================================
   // Cyclic scanner
   // =========================================================================
   // One entry at a time; a parameter store that never acknowledges stalls it.
   // cyclic fetch
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg       <= mbm_pkg::ST_IDLE;
         idx_reg         <= 4'h0;
         par_rd_req_out  <= 1'b0;
         par_rd_addr_out <= 16'h0000;
      end
      else
      begin
         par_rd_req_out <= 1'b0;
         unique case (state_reg)
            mbm_pkg::ST_IDLE:
            begin
               if (scan_reg[idx_reg] == mbm_pkg::SCAN_RESET)
                  idx_reg <= idx_reg + 4'h1;
               else
               begin
                  par_rd_req_out  <= 1'b1;
                  par_rd_addr_out <= scan_reg[idx_reg];
                  state_reg       <= mbm_pkg::ST_REQ;
               end
            end
            mbm_pkg::ST_REQ:
               state_reg <= mbm_pkg::ST_WAIT;
            mbm_pkg::ST_WAIT:
            begin
               if (par_rd_ack_in)
               begin
                  idx_reg   <= idx_reg + 4'h1;
                  state_reg <= mbm_pkg::ST_IDLE;
               end
            end
            default:
               state_reg <= mbm_pkg::ST_IDLE;
         endcase
      end
   end

   // =========================================================================
   // Data area cache
   // =========================================================================
   // A scan-list write wins over a fetch landing on the same slot, since the
   // fetched value belongs to the address that was just replaced.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < mbm_pkg::SLOTS; i++)
            value_reg[i] <= 32'h0000_0000;
         float_reg <= '0;
         wable_reg <= '0;
         valid_reg <= '0;
      end
      else
      begin
         if (state_reg == mbm_pkg::ST_IDLE && scan_reg[idx_reg] == mbm_pkg::SCAN_RESET)
            valid_reg[idx_reg] <= 1'b0;
         if (state_reg == mbm_pkg::ST_WAIT && par_rd_ack_in)
         begin
            value_reg[idx_reg] <= par_rd_data_in;
            float_reg[idx_reg] <= par_rd_float_in;
            wable_reg[idx_reg] <= par_rd_writable_in;
            valid_reg[idx_reg] <= par_rd_ok_in;
         end
         if (reg_wr_in && hit_scan)
            valid_reg[scan_idx] <= 1'b0;
      end
   end

   // =========================================================================
   // Register read path
   // =========================================================================
   // Any address in the map answers one cycle later; foreign addresses read 0.
   // any register of the area
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         reg_rdata_out <= 16'h0000;
         reg_ack_out   <= 1'b0;
      end
      else
      begin
         reg_ack_out   <= reg_rd_in || reg_wr_in;
         reg_rdata_out <= 16'h0000;
         if (reg_rd_in && hit_scan)
            reg_rdata_out <= scan_reg[scan_idx];
         else if (reg_rd_in && hit_data && valid_reg[slot])
         begin
            if (float_reg[slot])
               reg_rdata_out <= is_end ? rd_sw.dout[15:0] : rd_sw.dout[31:16];
            else if (!is_end)
               reg_rdata_out <= rd_sw.dout[15:0];
         end
      end
   end

   // =========================================================================
   // Register write path
   // =========================================================================
   // A float is forwarded only once its end register arrives after its start.
   // float start register staged
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         stage_reg       <= 16'h0000;
         stage_slot_reg  <= 4'h0;
         stage_valid_reg <= 1'b0;
      end
      else if (reg_wr_in && hit_data)
      begin
         stage_reg       <= reg_wdata_in;
         stage_slot_reg  <= slot;
         stage_valid_reg <= !is_end && float_reg[slot];
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         par_wr_out       <= 1'b0;
         par_wr_addr_out  <= 16'h0000;
         par_wr_data_out  <= 32'h0000_0000;
         par_wr_float_out <= 1'b0;
      end
      else
      begin
         par_wr_out <= 1'b0;
         if (reg_wr_in && hit_data && valid_reg[slot] && wable_reg[slot])
         begin
            if ((float_reg[slot] && is_end && stage_valid_reg && stage_slot_reg == slot)
                || (!float_reg[slot] && !is_end))
            begin
               par_wr_out       <= 1'b1;
               par_wr_addr_out  <= scan_reg[slot];
               par_wr_data_out  <= wr_sw.dout;
               par_wr_float_out <= float_reg[slot];
            end
         end
      end
   end

endmodule

// [verif/mbm_data_map_props.sv]
`timescale 1ns/1ps

// =============================================================
// Port checks of the data map front end.
module mbm_data_map_props
(
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   input wire logic        reg_rd_in,
   input wire logic        reg_wr_in,
   input wire logic        byte_order_wr_in,
   input wire logic        reg_ack_out,
   input wire logic        par_rd_req_out,
   input wire logic        par_rd_ack_in,
   input wire logic        par_rd_ok_in,
   input wire logic        par_rd_float_in,
   input wire logic        par_rd_writable_in,
   input wire logic        par_wr_out,
   input wire logic        par_wr_float_out,
   input wire logic [1:0]  byte_order_in,
   input wire logic [1:0]  byte_order_out,
   input wire logic [15:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic [15:0] par_rd_addr_out,
   input wire logic [15:0] par_wr_addr_out,
   input wire logic [31:0] par_rd_data_in,
   input wire logic [31:0] par_wr_data_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   logic in_data;
   logic unmapped;

   // Address decode; the gap between the two areas must read as zero.
   assign in_data  = reg_addr_in >= mbm_pkg::DATA_BASE && reg_addr_in <= mbm_pkg::DATA_LAST;
   assign unmapped = !in_data && (reg_addr_in < mbm_pkg::SCAN_BASE
                     || reg_addr_in > mbm_pkg::SCAN_LAST);

   a_ack_per_strobe:
      assert property ((reg_rd_in || reg_wr_in) |=> reg_ack_out) else $error("ack missing");
   a_ack_no_stray:
      assert property (!(reg_rd_in || reg_wr_in) |=> !reg_ack_out) else $error("stray ack");
   a_hole_reads_zero:
      assert property (reg_rd_in && unmapped |=> reg_rdata_out == 16'h0000)
         else $error("unmapped read not zero");
   a_order_load:
      assert property (byte_order_wr_in |=> byte_order_out == $past(byte_order_in))
         else $error("byte order not loaded");
   a_order_hold:
      assert property (!byte_order_wr_in |=> $stable(byte_order_out))
         else $error("byte order changed");
   a_fetch_spacing:
      assert property (par_rd_req_out |=> !par_rd_req_out [*3]) else $error("fetch too soon");
   a_fetch_not_empty:
      assert property (par_rd_req_out |-> par_rd_addr_out != mbm_pkg::SCAN_RESET)
         else $error("empty entry fetched");
   a_fetch_addr_hold:
      assert property ($changed(par_rd_addr_out) |-> par_rd_req_out)
         else $error("fetch address moved");
   a_forward_cause:
      assert property (par_wr_out |-> reg_ack_out && $past(reg_wr_in) && $past(in_data))
         else $error("forward without data write");
   a_forward_hold:
      assert property ($changed(par_wr_addr_out) |-> par_wr_out)
         else $error("forward address moved");

   c_float_fwd: cover property (par_wr_out && par_wr_float_out);
   c_fetch_done: cover property (par_rd_req_out ##[2:20] par_rd_ack_in);
   c_data_read: cover property (reg_rd_in && in_data ##1 reg_rdata_out != 16'h0000);
endmodule

bind mbm_data_map mbm_data_map_props i_mbm_data_map_props
(
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
   .byte_order_wr_in(byte_order_wr_in), .reg_ack_out(reg_ack_out),
   .par_rd_req_out(par_rd_req_out), .par_rd_ack_in(par_rd_ack_in),
   .par_rd_ok_in(par_rd_ok_in), .par_rd_float_in(par_rd_float_in),
   .par_rd_writable_in(par_rd_writable_in), .par_wr_out(par_wr_out),
   .par_wr_float_out(par_wr_float_out), .byte_order_in(byte_order_in),
   .byte_order_out(byte_order_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .par_rd_addr_out(par_rd_addr_out),
   .par_wr_addr_out(par_wr_addr_out), .par_rd_data_in(par_rd_data_in),
   .par_wr_data_out(par_wr_data_out)
);

// [verif/mbm_param_model.sv]
`timescale 1ns/1ps

// =============================================================
// Parameter store behind the scanner: 0x0101 writable float,
// 0x0102 writable integer, 0x0103 read-only float, all else unsupported.
module mbm_param_model
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        slow_in,
   input  wire logic        req_in,
   input  wire logic [15:0] addr_in,
   input  wire logic        wr_in,
   input  wire logic [15:0] wr_addr_in,
   input  wire logic [31:0] wr_data_in,
   output logic             ack_out,
   output logic             ok_out,
   output logic             flt_out,
   output logic             wrb_out,
   output logic [31:0]      data_out
);
   logic [31:0] mem_reg [4];
   logic [2:0]  cnt_reg;
   logic        tgl_reg;
   logic [1:0]  idx;
   logic        hit;

   assign idx = addr_in[1:0];
   assign hit = addr_in[15:2] == 14'h0040 && idx != 2'h0;
   // Outside an answer the lines toggle, so a stale value is never mistaken for data.
   assign ok_out   = ack_out ? hit : tgl_reg;
   assign flt_out  = ack_out ? addr_in[0] : ~tgl_reg;
   assign wrb_out  = ack_out ? idx != 2'h3 : tgl_reg;
   assign data_out = ack_out ? mem_reg[idx] : {32{tgl_reg}};

   // Answer three or six cycles after a fetch; accept writes to writable entries only.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mem_reg <= '{32'h0, 32'h40490FDB, 32'h00001234, 32'hC1A2B3C4};
         cnt_reg <= 3'h0;
         ack_out <= 1'b0;
         tgl_reg <= 1'b0;
      end
      else
      begin
         tgl_reg <= ~tgl_reg;
         ack_out <= cnt_reg == 3'h1;
         if (req_in)
            cnt_reg <= slow_in ? 3'h5 : 3'h2;
         else if (cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 3'h1;
         if (wr_in && wr_addr_in[15:2] == 14'h0040 && wr_addr_in[1:0] inside {2'h1, 2'h2})
            mem_reg[wr_addr_in[1:0]] <= wr_data_in;
      end
   end
endmodule

// [verif/modbus_byte_order_data_map_test.sv]
`timescale 1ns/1ps

module modbus_byte_order_data_map_test;
   logic        sys_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [15:0] reg_addr_in = 16'h0000;
   logic        reg_rd_in = 1'b0;
   logic        reg_wr_in = 1'b0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic        byte_order_wr_in = 1'b0;
   logic [1:0]  byte_order_in = 2'h0;
   logic        slow = 1'b0;
   logic [15:0] reg_rdata_out, par_rd_addr_out, par_wr_addr_out;
   logic        reg_ack_out, par_rd_req_out, par_rd_ack_in, par_rd_ok_in, par_rd_float_in;
   logic        par_rd_writable_in, par_wr_out, par_wr_float_out;
   logic [1:0]  byte_order_out;
   logic [31:0] par_rd_data_in, par_wr_data_out;
   logic [15:0] wq [32];
   logic [15:0] rq [32];
   logic [15:0] scan [16];
   logic [31:0] pv [4];
   int          n_fail = 0;
   int          total_checks = 0;
   int          n_wr = 0;

   mbm_data_map i_mbm_data_map
   (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
      .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
      .byte_order_wr_in(byte_order_wr_in), .byte_order_in(byte_order_in),
      .byte_order_out(byte_order_out), .par_rd_req_out(par_rd_req_out),
      .par_rd_addr_out(par_rd_addr_out), .par_rd_ack_in(par_rd_ack_in),
      .par_rd_ok_in(par_rd_ok_in), .par_rd_float_in(par_rd_float_in),
      .par_rd_writable_in(par_rd_writable_in), .par_rd_data_in(par_rd_data_in),
      .par_wr_out(par_wr_out), .par_wr_addr_out(par_wr_addr_out),
      .par_wr_data_out(par_wr_data_out), .par_wr_float_out(par_wr_float_out)
   );

   mbm_param_model i_mbm_param_model
   (
      .clk_in(sys_clk_in), .rst_in(rst_in), .slow_in(slow), .req_in(par_rd_req_out),
      .addr_in(par_rd_addr_out), .wr_in(par_wr_out), .wr_addr_in(par_wr_addr_out),
      .wr_data_in(par_wr_data_out), .ack_out(par_rd_ack_in), .ok_out(par_rd_ok_in),
      .flt_out(par_rd_float_in), .wrb_out(par_rd_writable_in), .data_out(par_rd_data_in)
   );

   // =============================================================
   // Clock and forwarded-write counter.
   always #5 sys_clk_in = ~sys_clk_in;

   always @(posedge sys_clk_in)
   begin
      if (par_wr_out === 1'b1)
         n_wr++;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Register pair as the master sees it; integers use the start register only.
   function automatic logic [15:0] enc(logic [1:0] o, logic [31:0] v, logic f, logic hi);
      if (!f)
         return hi ? 16'h0000 : (o inside {2'h0, 2'h3}) ? v[15:0] : {v[7:0], v[15:8]};
      case (o)
         mbm_pkg::ORD_1032: return hi ? v[31:16] : v[15:0];
         mbm_pkg::ORD_0123: return hi ? {v[23:16], v[31:24]} : {v[7:0], v[15:8]};
         mbm_pkg::ORD_2301: return hi ? {v[7:0], v[15:8]} : {v[23:16], v[31:24]};
         default: return hi ? v[15:0] : v[31:16];
      endcase
   endfunction

   // Back-to-back one-cycle strobes; each answer is taken one cycle after its strobe.
   task automatic access(input logic wr, input logic [15:0] a0, input int n);
      for (int j = 0; j < n + 2; j++)
      begin
         @(posedge sys_clk_in);
         if (j >= 2)
         begin
            check("ack", 32'(reg_ack_out), 32'h1);
            rq[j - 2] = reg_rdata_out;
         end
         reg_rd_in    <= !wr && j < n;
         reg_wr_in    <= wr && j < n;
         reg_addr_in  <= a0 + 16'(j);
         reg_wdata_in <= wq[j % 32];
      end
   endtask

   // Two fetches of slot 2 bracket a full pass over every other slot.
   task automatic settle();
      int seen;
      seen = 0;
      for (int i = 0; i < 2000 && seen < 2; i++)
      begin
         @(posedge sys_clk_in);
         if (par_rd_req_out === 1'b1 && par_rd_addr_out === 16'h0103)
            seen++;
      end
      if (seen < 2)
      begin
         n_fail++;
         complete_run();
      end
   endtask

   task automatic sweep(input logic [1:0] o);
      logic [15:0] a;
      logic [15:0] e;
      @(posedge sys_clk_in);
      byte_order_wr_in <= 1'b1;
      byte_order_in    <= o;
      @(posedge sys_clk_in);
      byte_order_wr_in <= 1'b0;
      @(posedge sys_clk_in);
      check("order", 32'(byte_order_out), 32'(o));
      access(1'b0, mbm_pkg::DATA_BASE, 32);
      for (int i = 0; i < 32; i++)
      begin
         a = scan[i / 2];
         e = (a[15:2] == 14'h0040 && a[1:0] != 2'h0) ? enc(o, pv[a[1:0]], a[0], i[0]) : 16'h0;
         check("data", 32'(rq[i]), 32'(e));
      end
   endtask

   // =============================================================
   // Main sequence.
   initial
   begin
      for (int i = 0; i < 16; i++)
         scan[i] = 16'h0000;
      pv = '{32'h0, 32'h40490FDB, 32'h00001234, 32'hC1A2B3C4};
      repeat (20) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
      check("order", 32'(byte_order_out), 32'(mbm_pkg::ORD_RESET));
      access(1'b0, mbm_pkg::SCAN_BASE, 16);
      check("scan", 32'(rq[15]), 32'(mbm_pkg::SCAN_RESET));
      access(1'b0, 16'h13A0, 1);
      check("hole", 32'(rq[0]), 32'h0);
      // Slot 3 names an unsupported place; slot 15 shares slot 0's parameter.
      scan[0]  = 16'h0101;
      scan[1]  = 16'h0102;
      scan[2]  = 16'h0103;
      scan[3]  = 16'h0777;
      scan[15] = 16'h0101;
      for (int i = 0; i < 16; i++)
         wq[i] = scan[i];
      access(1'b1, mbm_pkg::SCAN_BASE, 16);
      access(1'b0, mbm_pkg::SCAN_BASE, 16);
      for (int i = 0; i < 16; i++)
         check("scan", 32'(rq[i]), 32'(scan[i]));
      settle();
      for (int o = 0; o < 4; o++)
         sweep(2'(o));
      wq[0] = enc(mbm_pkg::ORD_3210, 32'h3F800000, 1'b1, 1'b0);
      wq[1] = enc(mbm_pkg::ORD_3210, 32'h3F800000, 1'b1, 1'b1);
      access(1'b1, mbm_pkg::DATA_BASE, 2);
      check("fwd", {par_wr_addr_out, 15'h0, par_wr_float_out}, 32'h01010001);
      check("fwdv", par_wr_data_out, 32'h3F800000);
      wq[0] = 16'hBEEF;
      access(1'b1, mbm_pkg::DATA_SLOT2, 1);
      check("fwdi", {par_wr_addr_out, par_wr_data_out[15:0]}, 32'h0102BEEF);
      access(1'b1, mbm_pkg::DATA_BASE + 16'h4, 4);
      @(posedge sys_clk_in);
      check("nwr", 32'(n_wr), 32'h2);
      pv[1] = 32'h3F800000;
      pv[2] = 32'h0000BEEF;
      slow <= 1'b1;
      settle();
      sweep(mbm_pkg::ORD_0123);
      complete_run();
   end
endmodule
